/* File: logic/vmc_pkg.sv */
/*
  shared constants, types and register map of the vector mask and
  compress unit; assumes one 125 MHz clock and an APB register port.
*/
// Overview of operation
// - low two select bits pick the element test; high bit enables compress
// - compress forms build the same mask and also write an index list
// - mask msb holds element 0, lsb holds element 63
// - code 0: mask bit set when the element equals zero
// - code 1: mask bit set when the element is nonzero
// - code 2: mask bit set when sign bit is clear; zero is positive
// - code 3: mask bit set only when sign bit is set
// - codes 4-7 test as 0-3 and store passing indices in order
// - destination written and pointer advanced only on pass; pointer starts 0
// - only vector-length elements tested; lower mask bits forced zero
// - compress with no passes clears mask and writes nothing
// - issue takes 1 clock; source freed length plus 3 after issue
// - compress destination ready length plus 10 after issue
// - mask ready length plus 4; mask-read consumers see it at plus 5
package vmc_pkg;

  // datapath shape
  localparam int ELEM_W   = 64;
  localparam int NUM_ELEM = 64;
  localparam int IDX_W    = 6;
  localparam int LEN_W    = 7;
  localparam int SEL_W    = 3;
  localparam int SEL_CMP_BIT = 2;
  localparam int SIGN_BIT = 63;

  // element tests, selected by the low two select bits
  typedef enum logic [1:0] {
    TEST_ZERO,
    TEST_NONZERO,
    TEST_POS,
    TEST_NEG
  } test_e;

  // timing in clock periods after issue, beyond the vector length
  localparam int CLK_PER_PRD   = 1;
  localparam int ISSUE_PRD     = 1;
  localparam int SRC_FREE_PRD  = 3;
  localparam int MASK_RDY_PRD  = 4;
  localparam int MASK_073_PRD  = 5;
  localparam int DEST_RDY_PRD  = 10;
  localparam int ISSUE_CYC     = ISSUE_PRD * CLK_PER_PRD;
  localparam int SRC_FREE_CYC  = SRC_FREE_PRD * CLK_PER_PRD;
  localparam int MASK_RDY_CYC  = MASK_RDY_PRD * CLK_PER_PRD;
  localparam int MASK_073_CYC  = MASK_073_PRD * CLK_PER_PRD;
  localparam int DEST_RDY_CYC  = DEST_RDY_PRD * CLK_PER_PRD;

  // register map, byte addresses
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS    = 12'h000;
  localparam logic [ADDR_W-1:0] VLEN_OFS    = 12'h004;
  localparam logic [ADDR_W-1:0] STAT_OFS    = 12'h008;
  localparam logic [ADDR_W-1:0] MASK_HI_OFS = 12'h00c;
  localparam logic [ADDR_W-1:0] MASK_LO_OFS = 12'h010;

  // fields and reset values
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RUN_BIT  = 1;
  localparam int STAT_CNT_LSB  = 8;
  localparam logic [SEL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [LEN_W-1:0] VLEN_RST = 7'h40;
  localparam logic [LEN_W-1:0] VLEN_MAX = 7'h40;

  // source element offered by the register file
  typedef struct packed {
    logic              valid;
    logic [ELEM_W-1:0] data;
  } src_elem_s;

  // compressed index write toward the destination register
  typedef struct packed {
    logic              we;
    logic [IDX_W-1:0]  addr;
    logic [ELEM_W-1:0] data;
  } dest_wr_s;

endpackage : vmc_pkg

/* File: logic/element_test.sv */
/*
  one-element test of the mask unit: zero, nonzero, positive, negative;
  assumes the caller registers the result.
*/
`timescale 1ns/1ps
module element_test (
  input  wire logic [vmc_pkg::ELEM_W-1:0] data_in,
  input  wire vmc_pkg::test_e             test_in,
  output logic                            pass_out
);
  import vmc_pkg::*;

  logic is_zero;
  logic is_neg;

  // shared detectors
  assign is_zero = (data_in == '0);
  assign is_neg  = data_in[SIGN_BIT];

  // test select
  always_comb begin
    case (test_in)
      TEST_ZERO:    pass_out = is_zero;
      TEST_NONZERO: pass_out = !is_zero;
      TEST_POS:     pass_out = !is_neg;
      TEST_NEG:     pass_out = is_neg;
      default:      pass_out = 1'b0;
    endcase
  end

endmodule : element_test

/* File: logic/vector_mask_compress_unit.sv */
/*
  vector mask and compress unit: tests source elements in order,
  builds the mask and an optional compressed index list.
  assumes issue logic keeps the hold conditions and the register file
  offers source elements with a valid flag; APB for control and status.
*/
`timescale 1ns/1ps
module vector_mask_compress_unit #(
  parameter int NUM_ELEM = vmc_pkg::NUM_ELEM
) (
  input  wire logic                          clk_in,
  input  wire logic                          nrst_in,
  // apb slave
  input  wire logic                          psel_in,
  input  wire logic                          penable_in,
  input  wire logic                          pwrite_in,
  input  wire logic [vmc_pkg::ADDR_W-1:0]    paddr_in,
  input  wire logic [31:0]                   pwdata_in,
  output logic [31:0]                        prdata_out,
  output logic                               pready_out,
  output logic                               pslverr_out,
  // issue side
  input  wire logic                          issue_in,
  output logic                               busy_out,
  output logic                               src_free_out,
  output logic                               mask_ready_out,
  output logic                               mask_073_ready_out,
  output logic                               dest_ready_out,
  // source vector register
  input  wire vmc_pkg::src_elem_s            src_in,
  output logic                               src_rd_out,
  output logic [vmc_pkg::IDX_W-1:0]          src_idx_out,
  // destination vector register and mask
  output vmc_pkg::dest_wr_s                  dest_out,
  output logic [NUM_ELEM-1:0]                vector_mask_out
);
  import vmc_pkg::*;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_RUN
  } state_e;

  state_e                 state;
  logic [SEL_W-1:0]       ctrl_sel;
  logic [LEN_W-1:0]       vector_length_reg;
  logic [SEL_W-1:0]       run_sel;
  logic [LEN_W-1:0]       run_len;
  logic [LEN_W-1:0]       elem_idx;
  logic [LEN_W-1:0]       dest_ptr;
  logic [NUM_ELEM-1:0]    mask_work;
  logic [NUM_ELEM-1:0]    next_mask;
  logic [DEST_RDY_CYC-1:0] fin_sr;
  logic [DEST_RDY_CYC-1:0] cmp_sr;
  logic                   pass;
  logic                   consume;
  logic                   accept;
  logic                   last_elem;
  logic                   finish;
  logic                   run_cmp;
  logic                   wr_en;
  logic                   rd_setup;
  logic [31:0]            rd_word;
  logic                   addr_ok;

  // element test on the current source element
  element_test u_test (
    .data_in  (src_in.data),
    .test_in  (test_e'(run_sel[1:0])),
    .pass_out (pass)
  );

  // handshake terms
  assign run_cmp   = run_sel[SEL_CMP_BIT];
  assign consume   = (state == ST_RUN) && src_in.valid;
  assign last_elem = (elem_idx + 7'h01 == run_len);
  assign accept    = issue_in && !busy_out;
  // a zero length finishes in the issue cycle itself
  assign finish    = (consume && last_elem) ||
                     (accept && vector_length_reg == '0);
  assign src_rd_out  = (state == ST_RUN);
  assign src_idx_out = elem_idx[IDX_W-1:0];

  // sequencing state
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
    end else if (accept && vector_length_reg != '0) begin
      state <= ST_RUN;
    end else if (consume && last_elem) begin
      state <= ST_IDLE;
    end
  end

  // instruction fields latched at issue
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_sel <= CTRL_RST;
      run_len <= VLEN_RST;
    end else if (accept) begin
      run_sel <= ctrl_sel;
      run_len <= vector_length_reg;
    end
  end

  // source element index, ascending from zero
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      elem_idx <= '0;
    end else if (accept) begin
      elem_idx <= '0;
    end else if (consume) begin
      elem_idx <= elem_idx + 7'h01;
    end
  end

  // mask bit per element; element 0 sits in the top bit
  generate
    for (genvar b = 0; b < NUM_ELEM; b++) begin : g_mask
      always_comb begin
        if (accept) begin
          next_mask[b] = 1'b0;
        end else if (consume &&
                     elem_idx[IDX_W-1:0] == IDX_W'(NUM_ELEM - 1 - b)) begin
          next_mask[b] = pass;
        end else begin
          next_mask[b] = mask_work[b];
        end
      end
    end
  endgenerate

  // working mask
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_work <= '0;
    end else begin
      mask_work <= next_mask;
    end
  end

  // published mask, updated once the last element is in
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      vector_mask_out <= '0;
    end else if (finish) begin
      vector_mask_out <= next_mask;
    end
  end

  // compressed index writes, only for passing elements
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dest_out <= '0;
    end else begin
      dest_out.we   <= consume && run_cmp && pass;
      dest_out.addr <= dest_ptr[IDX_W-1:0];
      dest_out.data <= ELEM_W'(elem_idx);
    end
  end

  // destination pointer
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dest_ptr <= '0;
    end else if (accept) begin
      dest_ptr <= '0;
    end else if (consume && run_cmp && pass) begin
      dest_ptr <= dest_ptr + 7'h01;
    end
  end

  // delay lines from the finishing cycle; overlapping instructions safe
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fin_sr <= '0;
      cmp_sr <= '0;
    end else begin
      fin_sr <= {fin_sr[DEST_RDY_CYC-2:0], finish};
      cmp_sr <= {cmp_sr[DEST_RDY_CYC-2:0],
                 accept ? ctrl_sel[SEL_CMP_BIT] : run_cmp};
    end
  end

  // timing pulses toward issue logic
  assign src_free_out       = fin_sr[SRC_FREE_CYC-1];
  assign mask_ready_out     = fin_sr[MASK_RDY_CYC-1];
  assign mask_073_ready_out = fin_sr[MASK_073_CYC-1];
  assign dest_ready_out     = fin_sr[DEST_RDY_CYC-1] &&
                              cmp_sr[DEST_RDY_CYC-1];
  // unit busy until the mask is ready
  assign busy_out = (state == ST_RUN) ||
                    (|fin_sr[MASK_RDY_CYC-2:0]);

  // apb decode
  assign wr_en    = psel_in && penable_in && pwrite_in;
  assign rd_setup = psel_in && !penable_in && !pwrite_in;
  assign addr_ok  = paddr_in == CTRL_OFS || paddr_in == VLEN_OFS ||
                    paddr_in == STAT_OFS || paddr_in == MASK_HI_OFS ||
                    paddr_in == MASK_LO_OFS;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_ok;

  // control registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_sel          <= CTRL_RST;
      vector_length_reg <= VLEN_RST;
    end else if (wr_en && paddr_in == CTRL_OFS) begin
      ctrl_sel <= pwdata_in[SEL_W-1:0];
    end else if (wr_en && paddr_in == VLEN_OFS) begin
      // lengths above the register size saturate
      vector_length_reg <= (pwdata_in > 32'(VLEN_MAX)) ?
                           VLEN_MAX : pwdata_in[LEN_W-1:0];
    end
  end

  // read mux
  always_comb begin
    rd_word = '0;
    case (paddr_in)
      CTRL_OFS:    rd_word[SEL_W-1:0] = ctrl_sel;
      VLEN_OFS:    rd_word[LEN_W-1:0] = vector_length_reg;
      STAT_OFS: begin
        rd_word[STAT_BUSY_BIT] = busy_out;
        rd_word[STAT_RUN_BIT]  = (state == ST_RUN);
        rd_word[STAT_CNT_LSB +: LEN_W] = dest_ptr;
      end
      MASK_HI_OFS: rd_word = vector_mask_out[NUM_ELEM-1 -: 32];
      MASK_LO_OFS: rd_word = vector_mask_out[31:0];
      default:     rd_word = '0;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_out <= rd_word;
    end
  end

  // checks: selection and mask placement
  a_sel_decode: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    accept |=> (run_cmp == $past(ctrl_sel[SEL_CMP_BIT])))
    else $error("compress select not taken from high bit");

  a_mask_bit_place: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    consume |=> mask_work[NUM_ELEM-1-$past(elem_idx[IDX_W-1:0])] ==
               $past(pass))
    else $error("mask bit landed at wrong position");

  // element tests, one per code
  a_zero_test: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    consume && run_sel[1:0] == 2'h0 |-> pass == (src_in.data == '0))
    else $error("zero test wrong");

  a_nonzero_test: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    consume && run_sel[1:0] == 2'h1 |-> pass == (src_in.data != '0))
    else $error("nonzero test wrong");

  a_pos_test: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    consume && run_sel[1:0] == 2'h2 |-> pass == !src_in.data[SIGN_BIT])
    else $error("positive test wrong");

  a_neg_test: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    consume && run_sel[1:0] == 2'h3 |-> pass == src_in.data[SIGN_BIT])
    else $error("negative test wrong");

  // compressed index list
  a_index_write: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    consume && run_cmp && pass |=>
      dest_out.we && dest_out.data == ELEM_W'($past(elem_idx)))
    else $error("passing index not written");

  a_write_only_pass: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    dest_out.we |-> $past(consume && run_cmp && pass, 1))
    else $error("destination written without a pass");

  a_ptr_step: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    dest_out.we && !accept |-> dest_ptr == {1'b0, dest_out.addr} + 7'h01)
    else $error("destination pointer did not advance");

  a_ptr_start: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    accept |=> dest_ptr == '0 && elem_idx == '0)
    else $error("pointers not cleared at issue");

  a_tail_zero: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    mask_ready_out && run_len < VLEN_MAX && !$past(accept, 3) |->
      (vector_mask_out & ({NUM_ELEM{1'b1}} >> run_len)) == '0)
    else $error("mask bits past the length not zero");

  a_len_latch: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    accept |=> run_len == $past(vector_length_reg))
    else $error("vector length not taken at issue");

  a_no_pass_none: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    finish && run_cmp && next_mask == '0 && state == ST_RUN |->
      dest_ptr == '0)
    else $error("write happened with no passing element");

  // timing pulses after the last element
  a_src_free_time: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    finish |-> ##3 src_free_out ##1 mask_ready_out)
    else $error("source free or mask ready late");

  a_mask_073_time: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    mask_ready_out |=> mask_073_ready_out)
    else $error("mask read ready not one after mask ready");

  a_dest_time: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    finish && (accept ? ctrl_sel[SEL_CMP_BIT] : run_cmp)
      |-> ##10 dest_ready_out)
    else $error("destination ready not at ten after finish");

  a_busy_end: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    src_free_out |-> busy_out ##1 !busy_out)
    else $error("unit busy window wrong");

  // issue sequencing
  a_order_up: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    consume && !last_elem |=> elem_idx == $past(elem_idx) + 7'h01)
    else $error("elements not taken in ascending order");

endmodule : vector_mask_compress_unit

/* File: tb/src_reg_model.sv */
/*
  source vector register model for the mask and compress unit;
  assumes the bench supplies element contents and a stall pattern.
*/
`timescale 1ns/1ps
module src_reg_model (
  input  wire logic                       stall_in,
  input  wire logic                       src_rd_in,
  input  wire logic [vmc_pkg::IDX_W-1:0]  src_idx_in,
  input  wire logic [vmc_pkg::ELEM_W-1:0] elems_in [vmc_pkg::NUM_ELEM],
  output vmc_pkg::src_elem_s              src_out
);
  import vmc_pkg::*;
  // data valid only while read and not stalled; otherwise inverted junk
  always_comb begin
    src_out.valid = src_rd_in & ~stall_in;
    src_out.data  = src_out.valid ? elems_in[src_idx_in]
                                  : ~elems_in[src_idx_in];
  end
endmodule : src_reg_model

/* File: tb/vector_mask_compress_unit_tb_top.sv */
/*
  bench of the mask and compress unit: apb setup, issue, element flow,
  masks and index lists; assumes src_reg_model on the source side.
*/
`timescale 1ns/1ps
module vector_mask_compress_unit_tb_top;
  import vmc_pkg::*;
  logic              clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, dmy;
  logic              pready, pslverr, dmy_e, issue = 0, busy, stl = 0;
  logic              src_free, mrdy, m073, drdy, src_rd, busy_f, busy_m;
  logic [IDX_W-1:0]  src_idx;
  src_elem_s         src;
  dest_wr_s          dest;
  logic [63:0]       vmask, last_mask;
  logic [ELEM_W-1:0] elems [NUM_ELEM];
  logic [63:0]       dq[$], aq[$];
  int cyc = 0, take_c, free_c, mrdy_c, m073_c, drdy_c, n_free;
  int fail_count = 0, check_count = 0;
  wire logic stall = stl && (cyc % 3 == 1);

  always #4 clk = ~clk;

  vector_mask_compress_unit vector_mask_compress_unit_i (
    .clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .issue_in(issue), .busy_out(busy), .src_free_out(src_free),
    .mask_ready_out(mrdy), .mask_073_ready_out(m073),
    .dest_ready_out(drdy), .src_in(src), .src_rd_out(src_rd),
    .src_idx_out(src_idx), .dest_out(dest), .vector_mask_out(vmask));
  src_reg_model src_reg_model_i (
    .stall_in(stall), .src_rd_in(src_rd), .src_idx_in(src_idx),
    .elems_in(elems), .src_out(src));

  // event cycles and destination writes, sampled at each rising edge
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (src_rd && src.valid) take_c <= cyc;
    if (src_free) free_c <= cyc;
    if (src_free) n_free <= n_free + 1;
    if (src_free) busy_f <= busy;
    if (mrdy) busy_m <= busy;
    if (mrdy) mrdy_c <= cyc;
    if (m073) m073_c <= cyc;
    if (drdy) drdy_c <= cyc;
    if (dest.we) dq.push_back(dest.data);
    if (dest.we) aq.push_back(dest.addr);
  end

  task automatic check(input string what, input logic [63:0] exp, got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdchk(input string what, input logic [ADDR_W-1:0] a,
                       input logic [63:0] exp, input logic xe);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    check(what, exp, {32'h0, d});
    check("slverr", {63'h0, xe}, {63'h0, e});
  endtask : rdchk

  function automatic logic passes(input logic [1:0] t, input logic [63:0] v);
    case (t)
      2'd0: return v == 64'h0;
      2'd1: return v != 64'h0;
      2'd2: return !v[63];
      default: return v[63];
    endcase
  endfunction : passes

  // one instruction: set up, issue (twice if dbl), then judge everything
  task automatic run(input logic [2:0] sel, input int len, input logic st,
                     input logic dbl);
    logic [63:0] em;
    logic [63:0] ex[$];
    int k;
    em = '0;
    for (int i = 0; i < len; i++) begin
      if (passes(sel[1:0], elems[i])) begin
        em[63 - i] = 1'b1;
        ex.push_back(i);
      end
    end
    k = 0;
    while (busy !== 1'b0 && k < 100) begin
      @(posedge clk);
      k++;
    end
    apb(1'b1, CTRL_OFS, {29'h0, sel}, dmy, dmy_e);
    apb(1'b1, VLEN_OFS, len, dmy, dmy_e);
    dq.delete();
    aq.delete();
    n_free = 0;
    {busy_f, busy_m} = 2'b01;
    {take_c, free_c, mrdy_c, m073_c, drdy_c} = {5{-32'sd1}};
    stl = st;
    issue <= 1'b1;
    @(posedge clk);
    issue <= dbl;
    @(posedge clk);
    issue <= 1'b0;
    check("busy_run", 64'h1, busy);
    k = 0;
    while ((m073_c < 0 || (sel[2] && drdy_c < 0)) && k < 400) begin
      @(posedge clk);
      k++;
    end
    last_mask = em;
    check("mask", em, vmask);
    check("src_free", take_c + 3, free_c);
    check("mask_rdy", take_c + 4, mrdy_c);
    check("mask_073", take_c + 5, m073_c);
    check("runs", 1, n_free);
    check("writes", sel[2] ? ex.size() : 0, dq.size());
    check("busy_free", 64'h1, busy_f);
    check("busy_mrdy", 64'h0, busy_m);
    // plain forms: wait past the compress ready point, no pulse may come
    if (!sel[2])
      repeat (6) @(posedge clk);
    check("dest_rdy", sel[2] ? take_c + 10 : -1, drdy_c);
    for (int i = 0; i < dq.size() && i < ex.size(); i++) begin
      check("index", ex[i], dq[i]);
      check("dest_ptr", i, aq[i]);
    end
  endtask : run

  task automatic t_regs;
    rdchk("ctrl_rst", CTRL_OFS, 64'h0, 1'b0);
    rdchk("vlen_rst", VLEN_OFS, 64'h40, 1'b0);
    rdchk("unmapped", 12'h100, 64'h0, 1'b1);
    apb(1'b1, VLEN_OFS, 32'h64, dmy, dmy_e);
    rdchk("vlen_sat", VLEN_OFS, 64'h40, 1'b0);
  endtask : t_regs

  // every test code, plain and compress, over a full vector
  task automatic t_codes;
    for (int s = 0; s < 8; s++)
      run(s[2:0], 64, 1'b0, 1'b0);
  endtask : t_codes

  task automatic t_stall;
    run(3'd5, 64, 1'b1, 1'b0);
  endtask : t_stall

  // no element passes; then short length with an issue while busy
  task automatic t_edge;
    run(3'd7, 1, 1'b0, 1'b0);
    run(3'd6, 5, 1'b0, 1'b1);
  endtask : t_edge

  task automatic t_mask_regs;
    rdchk("mask_hi", MASK_HI_OFS, {32'h0, last_mask[63:32]}, 1'b0);
    rdchk("mask_lo", MASK_LO_OFS, {32'h0, last_mask[31:0]}, 1'b0);
    rdchk("stat_writes", STAT_OFS, 64'h300, 1'b0);
  endtask : t_mask_regs

  // reset pulled in the middle of a run, then a fresh compress run
  task automatic t_reset;
    apb(1'b1, CTRL_OFS, 32'h0000_0005, dmy, dmy_e);
    issue <= 1'b1;
    @(posedge clk);
    issue <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    check("rst_busy", 64'h0, busy);
    check("rst_mask", 64'h0, vmask);
    check("rst_we", 64'h0, dest.we);
    nrst <= 1'b1;
    @(posedge clk);
    rdchk("rst_ctrl", CTRL_OFS, 64'h0, 1'b0);
    run(3'd4, 2, 1'b0, 1'b0);
  endtask : t_reset

  // element contents, reset, then the scenarios
  initial begin
    for (int i = 0; i < NUM_ELEM; i++) begin
      case (i % 4)
        0: elems[i] = 64'h0;
        1: elems[i] = 64'(i + 5);
        2: elems[i] = {1'b1, 57'h0, 6'(i)};
        default: elems[i] = '1;
      endcase
    end
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs;
    t_codes;
    t_stall;
    t_edge;
    t_mask_regs;
    t_reset;
    conclude;
  end

  // watchdog well beyond the expected run length
  initial begin
    #(8 * 20000);
    fail_count++;
    conclude;
  end
endmodule : vector_mask_compress_unit_tb_top
